// *** pkg/skc_cfg.svh ***
// Constants for the serial key command logic.
// Assumes inclusion by bare name from the design module and the bench.
`ifndef SKC_CFG_SVH
`define SKC_CFG_SVH
`define SKC_CODE_READ 8'h46
`define SKC_CODE_WRITE 8'hb9
`define SKC_MODE_PROG 2'h2
`define SKC_MODE_NORM 2'h1
`define SKC_CMD_BITS 8'h18
`define SKC_ID_BITS 8'h40
`define SKC_MEM_BITS 8'h80
`define SKC_BUS_CODE_DFLT 13'h0000
`define SKC_LFSR_SEED 16'hace1
`endif

// *** pkg/skc_pkg.sv ***
// Types shared by the serial key command logic.
// Assumes the bench and the design compile this before the design module.
package skc_pkg;
   typedef enum logic [2:0] {
      SKC_IDLE = 3'h0,
      SKC_CMD = 3'h1,
      SKC_IDOUT = 3'h3,
      SKC_PASS = 3'h2,
      SKC_MEM = 3'h6,
      SKC_PROG = 3'h5,
      SKC_ABORT = 3'h4
   } skc_state_e;
   typedef struct packed {
      logic [127:0] mem;
      logic [63:0] ident;
      logic [63:0] match;
   } skc_store_s;
endpackage : skc_pkg

// *** logic/skc_key.sv ***
// Serial key access logic: command decode, identification, password and memory.
// Assumes link pins arrive asynchronously and are sampled by CORE_CLK_I.
`include "skc_cfg.svh"
// Function
// - First byte must be read or write
// - Mode bits 10 select program mode
// - Program mode only with write code
// - Mode bits 01 select normal mode
// - Mode bits 00 or 11 abort
// - Thirteen bus code bits must match configuration
// - Last command bit must be one
// - Raised gate starts command shifting
// - Low gate ends transfer, releases data
// - Bit period is fall then rise
// - Inputs sampled on rising clock edge
// - Read bits driven on falling edge
// - Rising edge releases the data line
// - Normal mode outputs 64 identification bits
// - Host writes 64 password bits, compared
// - Mismatch gives random reads, ignores writes
// - Program mode stores identification then match
module skc_key (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic GATE_I,
   input wire logic SCLK_I,
   input wire logic DATA_I,
   output logic DATA_O,
   output logic DATA_OE_O,
   input wire logic [12:0] BUS_CODE_I,
   output logic BUSY_O,
   output logic ABORT_O,
   output logic MATCH_O
);
   // Synchronised pin samples and the edges found in them.
   logic [2:0] gate_sync_reg;
   logic [2:0] sclk_sync_reg;
   logic [1:0] data_sync_reg;
   logic rise;
   logic fall;
   logic gate;

   skc_pkg::skc_state_e state_reg;
   logic [7:0] cnt_reg;
   logic [23:0] cmd_reg;
   logic [63:0] pass_reg;
   logic is_write_reg;
   logic match_reg;
   logic [15:0] lfsr_reg;
   skc_pkg::skc_store_s store_reg;

   // Decoded command and positions inside the running phase.
   logic [23:0] cmd_full;
   logic cmd_ok;
   logic prog_sel;
   logic last_bit;
   logic [6:0] mem_idx;
   logic [5:0] id_idx;

   logic [12:0] bus_code_meta_reg;
   logic [12:0] bus_code_reg;

   // Decode a full command word; bit 0 of each byte was shifted first.
   function automatic logic cmd_valid(input logic [23:0] c, input logic [12:0] code);
      logic first_ok;
      logic mode_ok;
      logic code_ok;
      logic stop_ok;
      first_ok = 1'b0;
      mode_ok = 1'b0;
      code_ok = 1'b0;
      stop_ok = 1'b0;
      first_ok = (c[7:0] == `SKC_CODE_READ) || (c[7:0] == `SKC_CODE_WRITE);
      mode_ok = (c[9:8] == `SKC_MODE_NORM) || (c[9:8] == `SKC_MODE_PROG);
      if (c[9:8] == `SKC_MODE_PROG && c[7:0] != `SKC_CODE_WRITE) begin
         mode_ok = 1'b0;
      end
      code_ok = (c[22:10] == code);
      stop_ok = c[23];
      cmd_valid = first_ok && mode_ok && code_ok && stop_ok;
   endfunction : cmd_valid

   // Bit position inside a phase. Indexing instead of rotating keeps the store intact
   // when the host cuts a phase short with the gate.
   function automatic logic [6:0] bit_index(input logic [7:0] total, input logic [7:0] left);
      bit_index = 7'(total - left);
   endfunction : bit_index

   // Two flops before use; the third shift clock stage only feeds edge detection, and the third gate stage is unused.
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         gate_sync_reg <= 3'h0;
         sclk_sync_reg <= 3'h0;
         data_sync_reg <= 2'h0;
      end else begin
         gate_sync_reg <= {gate_sync_reg[1:0], GATE_I};
         sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK_I};
         data_sync_reg <= {data_sync_reg[0], DATA_I};
      end
   end

   // The bus code is a strap from outside this clock domain. It is only compared when a
   // command completes, so two flops per bit suffice as long as it changes between transfers.
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         bus_code_meta_reg <= `SKC_BUS_CODE_DFLT;
         bus_code_reg <= `SKC_BUS_CODE_DFLT;
      end else begin
         bus_code_meta_reg <= BUS_CODE_I;
         bus_code_reg <= bus_code_meta_reg;
      end
   end

   assign gate = gate_sync_reg[1];
   assign rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
   assign cmd_full = {data_sync_reg[1], cmd_reg[23:1]};
   assign cmd_ok = cmd_valid(cmd_full, bus_code_reg);
   assign prog_sel = (cmd_full[9:8] == `SKC_MODE_PROG);
   assign last_bit = (cnt_reg == 8'h01);
   assign mem_idx = bit_index(`SKC_MEM_BITS, cnt_reg);
   assign id_idx = 6'(bit_index(`SKC_ID_BITS, cnt_reg));

   // Sequencer; every phase counts down its bit periods on rising edges.
   // A finished memory or program phase, or a rejected command, parks in the abort state, which only a low gate leaves.
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_reg <= skc_pkg::SKC_IDLE;
         cnt_reg <= 8'h00;
      end else if (!gate) begin
         state_reg <= skc_pkg::SKC_IDLE;
         cnt_reg <= 8'h00;
      end else begin
         case (state_reg)
            skc_pkg::SKC_IDLE: begin
               state_reg <= skc_pkg::SKC_CMD;
               cnt_reg <= `SKC_CMD_BITS;
            end
            skc_pkg::SKC_CMD: begin
               if (rise) begin
                  cnt_reg <= cnt_reg - 8'h01;
                  if (last_bit) begin
                     if (!cmd_ok) begin
                        state_reg <= skc_pkg::SKC_ABORT;
                     end else if (prog_sel) begin
                        state_reg <= skc_pkg::SKC_PROG;
                        cnt_reg <= `SKC_MEM_BITS;
                     end else begin
                        state_reg <= skc_pkg::SKC_IDOUT;
                        cnt_reg <= `SKC_ID_BITS;
                     end
                  end
               end
            end
            skc_pkg::SKC_IDOUT: begin
               if (rise) begin
                  cnt_reg <= cnt_reg - 8'h01;
                  if (last_bit) begin
                     state_reg <= skc_pkg::SKC_PASS;
                     cnt_reg <= `SKC_ID_BITS;
                  end
               end
            end
            skc_pkg::SKC_PASS: begin
               if (rise) begin
                  cnt_reg <= cnt_reg - 8'h01;
                  if (last_bit) begin
                     state_reg <= skc_pkg::SKC_MEM;
                     cnt_reg <= `SKC_MEM_BITS;
                  end
               end
            end
            skc_pkg::SKC_MEM, skc_pkg::SKC_PROG: begin
               if (rise) begin
                  cnt_reg <= cnt_reg - 8'h01;
                  if (last_bit) begin
                     state_reg <= skc_pkg::SKC_ABORT;
                  end
               end
            end
            skc_pkg::SKC_ABORT: begin
               state_reg <= skc_pkg::SKC_ABORT;
            end
            default: begin
               state_reg <= skc_pkg::SKC_IDLE;
            end
         endcase
      end
   end

   // Command and password shift registers.
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cmd_reg <= 24'h000000;
         pass_reg <= 64'h0;
         is_write_reg <= 1'b0;
      end else if (rise && state_reg == skc_pkg::SKC_CMD) begin
         cmd_reg <= cmd_full;
         is_write_reg <= (cmd_full[7:0] == `SKC_CODE_WRITE);
      end else if (rise && state_reg == skc_pkg::SKC_PASS) begin
         pass_reg <= {data_sync_reg[1], pass_reg[63:1]};
      end
   end

   // Match flag is decided on the last password bit and holds until the gate goes low.
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         match_reg <= 1'b0;
      end else if (!gate) begin
         match_reg <= 1'b0;
      end else if (rise && state_reg == skc_pkg::SKC_PASS && last_bit) begin
         match_reg <= ({data_sync_reg[1], pass_reg[63:1]} == store_reg.match);
      end
   end

   // Store, written one bit at a time where the phase counter points.
   // A cut program phase leaves the bits not yet reached as they were.
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         store_reg <= '0;
      end else if (gate && rise) begin
         if (state_reg == skc_pkg::SKC_PROG) begin
            if (mem_idx[6]) begin
               store_reg.match[mem_idx[5:0]] <= data_sync_reg[1];
            end else begin
               store_reg.ident[mem_idx[5:0]] <= data_sync_reg[1];
            end
         end else if (state_reg == skc_pkg::SKC_MEM && match_reg && is_write_reg) begin
            store_reg.mem[mem_idx] <= data_sync_reg[1];
         end
      end
   end

   // Pseudo-random source for denied reads; a simple 16-bit maximal LFSR.
   // Its sequence repeats, so denied reads are unhelpful rather than secret.
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         lfsr_reg <= `SKC_LFSR_SEED;
      end else if (rise) begin
         lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      end
   end

   // Data pin driver. Release wins over drive, so a gate drop or a rising edge seen
   // together with a falling edge never leaves the line driven.
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         DATA_O <= 1'b0;
         DATA_OE_O <= 1'b0;
      end else if (!gate) begin
         DATA_OE_O <= 1'b0;
      end else if (rise) begin
         DATA_OE_O <= 1'b0;
      end else if (fall) begin
         if (state_reg == skc_pkg::SKC_IDOUT) begin
            DATA_O <= store_reg.ident[id_idx];
            DATA_OE_O <= 1'b1;
         end else if (state_reg == skc_pkg::SKC_MEM && !is_write_reg) begin
            DATA_O <= match_reg ? store_reg.mem[mem_idx] : lfsr_reg[0];
            DATA_OE_O <= 1'b1;
         end
      end
   end

   // Status flags come from flops so the pins never glitch while the state changes.
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         BUSY_O <= 1'b0;
         ABORT_O <= 1'b0;
      end else begin
         BUSY_O <= (state_reg != skc_pkg::SKC_IDLE) && (state_reg != skc_pkg::SKC_ABORT);
         ABORT_O <= (state_reg == skc_pkg::SKC_ABORT);
      end
   end

   assign MATCH_O = match_reg;
endmodule : skc_key

// *** testbench/skc_host.sv ***
// Host model: drives the gate, the shift clock and the host side of data.
// Assumes the bench resolves the pulled-down data line into dq_i.
module skc_host (
   input wire logic clk_i,
   input wire logic dq_i,
   output logic gate_o,
   output logic sclk_o,
   output logic d_o,
   output logic oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic bit_x(input logic wb, input logic drv, output logic rb);
      @(negedge clk_i);
      sclk_o = 1'b0;
      oe_o = drv;
      d_o = wb;
      repeat (8) @(negedge clk_i);
      rb = dq_i;
      sclk_o = 1'b1;
      repeat (7) @(negedge clk_i);
   endtask : bit_x
   task automatic gate(input logic g);
      oe_o = 1'b0;
      gate_o = g;
      repeat (5) @(negedge clk_i);
   endtask : gate
   initial begin
      {gate_o, sclk_o, d_o, oe_o} = 4'h4;
   end
endmodule : skc_host

// *** testbench/skc_key_assertions.sv ***
// Checker for the key's pin behaviour.
// Assumes it is bound to the key top with its own port names.
module skc_key_assertions (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic GATE_I,
   input wire logic SCLK_I,
   input wire logic DATA_I,
   input wire logic DATA_O,
   input wire logic DATA_OE_O,
   input wire logic [12:0] BUS_CODE_I,
   input wire logic BUSY_O,
   input wire logic ABORT_O,
   input wire logic MATCH_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   chk_gate_low_idle: assert property (!GATE_I [*5] |-> !DATA_OE_O && !BUSY_O)
      else $error("key active with gate low");
   chk_rise_release: assert property ($rose(SCLK_I) |-> ##[1:6] !DATA_OE_O)
      else $error("data not released after rise");
   chk_fall_drive: assert property ($rose(DATA_OE_O) |-> !SCLK_I && GATE_I)
      else $error("drive began outside low phase");
   chk_drive_stands: assert property ($fell(DATA_OE_O) |-> SCLK_I || !GATE_I)
      else $error("drive dropped in low phase");
   chk_busy_gated: assert property ($rose(BUSY_O) |-> GATE_I)
      else $error("busy without gate");
   chk_abort_quiet: assert property (ABORT_O [*4] |-> !DATA_OE_O && !BUSY_O)
      else $error("aborted key still active");
   chk_abort_holds: assert property ((ABORT_O && GATE_I) [*4] |=> ABORT_O || !GATE_I)
      else $error("abort left while gated");
   chk_match_clear: assert property (!GATE_I [*5] |-> !MATCH_O)
      else $error("match kept with gate low");
endmodule : skc_key_assertions

// *** testbench/testbench.sv ***
// Bench for the key: program, bad commands and normal sessions.
// Assumes the host model and the checker are compiled first.
`include "skc_cfg.svh"
bind skc_key skc_key_assertions skc_key_assertions_i (.CORE_CLK_I(CORE_CLK_I),
   .RST_I(RST_I), .GATE_I(GATE_I), .SCLK_I(SCLK_I), .DATA_I(DATA_I), .DATA_O(DATA_O),
   .DATA_OE_O(DATA_OE_O), .BUS_CODE_I(BUS_CODE_I), .BUSY_O(BUSY_O), .ABORT_O(ABORT_O),
   .MATCH_O(MATCH_O));
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [12:0] bus;
   logic d_o, d_oe, busy, abort_f, match_f, gate, sclk, hd, hoe, dq, g_match;
   int fail_count = 0;
   int compares = 0;
   logic [63:0] id, mt, g_id;
   logic [127:0] mem, g_mem;
   logic [23:0] bad [7];
   always #5 clk = ~clk;
   // Data line has a pull-down, so an undriven line reads low.
   assign dq = d_oe ? d_o : (hoe ? hd : 1'b0);
   skc_host skc_host_i (.clk_i(clk), .dq_i(dq), .gate_o(gate), .sclk_o(sclk), .d_o(hd),
      .oe_o(hoe));
   skc_key skc_key_i (.CORE_CLK_I(clk), .RST_I(rst), .GATE_I(gate), .SCLK_I(sclk),
      .DATA_I(dq), .DATA_O(d_o), .DATA_OE_O(d_oe), .BUS_CODE_I(bus), .BUSY_O(busy),
      .ABORT_O(abort_f), .MATCH_O(match_f));
   function automatic logic [23:0] cmd(logic [7:0] c, logic [1:0] m);
      return {1'b1, bus, m, c};
   endfunction : cmd
   task automatic check(input logic [127:0] g, input logic [127:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : check
   task automatic xfer(input int n, input logic wr, input logic [127:0] w,
      output logic [127:0] r);
      logic b;
      r = '0;
      for (int i = 0; i < n; i++) begin
         skc_host_i.bit_x(w[i], wr, b);
         r[i] = b;
      end
   endtask : xfer
   task automatic sess(input logic [7:0] c, input logic [63:0] pw, input logic [127:0] w);
      skc_host_i.gate(1'b1);
      xfer(24, 1'b1, {104'h0, cmd(c, `SKC_MODE_NORM)}, g_mem);
      xfer(64, 1'b0, '0, g_mem);
      g_id = g_mem[63:0];
      check({busy, abort_f}, 2'b10);
      xfer(64, 1'b1, {64'h0, pw}, g_mem);
      g_match = match_f;
      xfer(128, c == `SKC_CODE_WRITE, w, g_mem);
      check({busy, abort_f}, 2'b01);
      skc_host_i.gate(1'b0);
   endtask : sess
   task automatic end_sim;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   initial begin
      void'($urandom(32'h9dd473d3));
      bus = 13'($urandom);
      id = {$urandom, $urandom};
      mt = {$urandom, $urandom};
      mem = {$urandom, $urandom, $urandom, $urandom};
      repeat (2) @(negedge clk);
      rst = 1'b0;
      skc_host_i.gate(1'b1);
      xfer(24, 1'b1, {104'h0, cmd(`SKC_CODE_WRITE, `SKC_MODE_PROG)}, g_mem);
      xfer(128, 1'b1, {mt, id}, g_mem);
      check(abort_f, 1'b1);
      skc_host_i.gate(1'b0);
      $display("test program done");
      // The strap changes between transfers; the last entry carries the old code.
      bus = ~bus;
      bad = '{cmd(8'h47, `SKC_MODE_NORM), cmd(`SKC_CODE_READ, 2'h0),
         cmd(`SKC_CODE_READ, 2'h3), cmd(`SKC_CODE_READ, `SKC_MODE_PROG),
         cmd(`SKC_CODE_WRITE, `SKC_MODE_NORM) ^ (24'h400 << $urandom_range(12)),
         cmd(`SKC_CODE_WRITE, `SKC_MODE_NORM) ^ 24'h800000,
         cmd(`SKC_CODE_WRITE, `SKC_MODE_NORM) ^ {1'b0, 13'h1fff, 10'h000}};
      foreach (bad[i]) begin
         skc_host_i.gate(1'b1);
         xfer(24, 1'b1, {104'h0, bad[i]}, g_mem);
         xfer(8, 1'b0, '0, g_mem);
         check({abort_f, g_mem[7:0]}, 9'h100);
         skc_host_i.gate(1'b0);
      end
      $display("test bad commands done");
      sess(`SKC_CODE_WRITE, mt, mem);
      check({g_match, g_id}, {1'b1, id});
      sess(`SKC_CODE_READ, mt, '0);
      check(g_mem, mem);
      sess(`SKC_CODE_WRITE, ~mt, ~mem);
      check(g_match, 1'b0);
      sess(`SKC_CODE_READ, mt, '0);
      check(g_mem, mem);
      sess(`SKC_CODE_READ, ~mt, '0);
      check(g_mem == mem || g_mem == '0, 1'b0);
      $display("test sessions done");
      end_sim();
   end
   initial begin
      #500000;
      fail_count++;
      end_sim();
   end
endmodule : testbench
